// ==== core/sfp_pkg.sv ====
package sfp_pkg;
    localparam int SECTORS = 4;
    localparam int SECTOR_BYTES = 32768;
    localparam int ADDR_W = 17;
    localparam int SECT_LSB = 15;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] OP_WRITE_UNLOCK_CMD = 8'h06;
    localparam logic [7:0] OP_WRITE_RELOCK_CMD = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PP = 8'h02;
    localparam logic [7:0] OP_SECT = 8'hD8;
    localparam logic [7:0] OP_BULK = 8'hC7;
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE = 8'hAB;
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 3;
    localparam int BIT_LOCK = 7;
    localparam logic [7:0] STATUS_WMASK = 8'h8C;
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic LOCK_RESET = 1'b0;
    localparam int CLK_HZ = 40000000;
    localparam int PUW_US = 10;
    localparam int PUW_CYC = (PUW_US * (CLK_HZ / 1000000) > 0) ?
        PUW_US * (CLK_HZ / 1000000) : 1;
    localparam int STAT_WR_CYC = 64;
    localparam int PROG_CYC = 256;
    localparam int SECT_CYC = 1024;
    localparam int BULK_CYC = 2048;
    typedef enum logic [1:0] {
        SFP_CYC_NONE, SFP_CYC_STAT, SFP_CYC_PROG, SFP_CYC_ERASE
    } sfp_cyc_t;
    typedef enum logic [1:0] {
        SFP_PWR_STANDBY, SFP_PWR_ACTIVE, SFP_PWR_DEEP
    } sfp_pwr_t;
endpackage : sfp_pkg

// ==== core/sfp_cmd_if.sv ====
`timescale 1ns/10ps
interface sfp_cmd_if;
    logic rise;
    logic fall;
    logic sdi;
    logic paused;
    modport link (output rise, output fall, output sdi, output paused);
    modport core (input rise, input fall, input sdi, input paused);
endinterface : sfp_cmd_if

// ==== core/sfp_link.sv ====
`timescale 1ns/10ps
module sfp_link
    import sfp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck_pin,
    input wire logic sdi_pin,
    input wire logic cs_n_pin,
    input wire logic hold_n_pin,
    output logic cs_n,
    sfp_cmd_if.link lk
);
    logic [3:0] s1_q, s2_q, s1_d, s2_d;
    logic sck_q, sck_d, hold_q, hold_d, pause_q, pause_d;
    always_comb begin
        s1_d = {sck_pin, sdi_pin, cs_n_pin, hold_n_pin};
        s2_d = s1_q;
        sck_d = s2_q[3];
        hold_d = s2_q[0];
        pause_d = pause_q;
        // Entry and exit wait for a low serial clock; deselect ends a pause at once
        if (s2_q[1]) begin
            pause_d = 1'b0;
        end else if (!s2_q[3]) begin
            pause_d = !s2_q[0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 4'h3;
            s2_q <= 4'h3;
            sck_q <= 1'b0;
            hold_q <= 1'b1;
            pause_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            sck_q <= sck_d;
            hold_q <= hold_d;
            pause_q <= pause_d;
        end
    end
    assign cs_n = s2_q[1];
    // Clock edges are masked while paused
    assign lk.rise = s2_q[3] & ~sck_q & ~pause_q;
    assign lk.fall = ~s2_q[3] & sck_q & ~pause_q;
    assign lk.sdi = s2_q[2];
    assign lk.paused = pause_q;
endmodule : sfp_link

// ==== core/sfp_core.sv ====
`timescale 1ns/10ps
module sfp_core
    import sfp_pkg::*;
#(
    parameter int PUW_CYCLES = PUW_CYC,
    parameter int BULK_CYCLES = BULK_CYC,
    parameter int SECT_CYCLES = SECT_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic guard_n,
    output logic sdo,
    output logic sdo_oe,
    output logic busy,
    output logic active,
    output logic deep_sleep,
    output logic [7:0] status_word,
    output logic wipe_strobe,
    output logic [1:0] wipe_sector,
    output logic wipe_all,
    output logic prog_strobe,
    output logic [ADDR_W-1:0] prog_addr,
    output logic [7:0] prog_mask
);
    import sfp_pkg::*;
    logic r1_q, rst_n;
    logic cs_n_s;
    sfp_cmd_if cmd ();
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            r1_q <= 1'b1;
            rst_n <= r1_q;
        end
    end
    sfp_link u_link (
        .clk(clk),
        .rst_n(rst_n),
        .sck_pin(sck),
        .sdi_pin(sdi),
        .cs_n_pin(cs_n),
        .hold_n_pin(hold_n),
        .cs_n(cs_n_s),
        .lk(cmd.link)
    );
    logic g1_q, g2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            g1_q <= 1'b1;
            g2_q <= 1'b1;
        end else begin
            g1_q <= guard_n;
            g2_q <= g1_q;
        end
    end

    function automatic logic sect_prot(input logic [1:0] bp,
                                       input logic [1:0] sect);
        unique case (bp)
            2'h0: sect_prot = 1'b0;
            2'h1: sect_prot = (sect == 2'h3);
            2'h2: sect_prot = sect[1];
            default: sect_prot = 1'b1;
        endcase
    endfunction : sect_prot

    logic [7:0] sh_q, sh_d, op_q, op_d, data_q, data_d, out_q, out_d;
    logic [12:0] nbits_q, nbits_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic cs_q, cs_d, wel_q, wel_d, lock_q, lock_d, deep_q, deep_d;
    logic [1:0] bp_q, bp_d, bpn_q, bpn_d;
    logic lockn_q, lockn_d;
    sfp_cyc_t cyc_q, cyc_d;
    logic [11:0] cnt_q, cnt_d;
    logic [$clog2(PUW_CYCLES+1)-1:0] puw_q, puw_d;
    logic wipe_d, wipe_all_d, prog_d, oe_d;
    logic [1:0] wsect_d;
    logic [ADDR_W-1:0] paddr_d;
    logic [7:0] pmask_d;
    logic blocked, hw_lock, end_frame, mult8;

    always_comb begin
        sh_d = sh_q;
        op_d = op_q;
        data_d = data_q;
        out_d = out_q;
        nbits_d = nbits_q;
        addr_d = addr_q;
        cs_d = !cs_n_s;
        wel_d = wel_q;
        lock_d = lock_q;
        bp_d = bp_q;
        bpn_d = bpn_q;
        lockn_d = lockn_q;
        deep_d = deep_q;
        cyc_d = cyc_q;
        cnt_d = cnt_q;
        puw_d = (puw_q != '0) ? puw_q - 1'b1 : puw_q;
        wipe_d = 1'b0;
        wipe_all_d = 1'b0;
        wsect_d = 2'h0;
        prog_d = 1'b0;
        paddr_d = prog_addr;
        pmask_d = prog_mask;
        blocked = (puw_q != '0);
        hw_lock = lock_q & !g2_q;
        end_frame = cs_q & cs_n_s;
        mult8 = (nbits_q[2:0] == 3'h0) && (nbits_q != 13'h0);
        // Internal cycle runs on whatever the link does
        if (cyc_q != SFP_CYC_NONE) begin
            if (cnt_q == 12'h0) begin
                if (cyc_q == SFP_CYC_STAT) begin
                    bp_d = bpn_q;
                    lock_d = lockn_q;
                end
                cyc_d = SFP_CYC_NONE;
                wel_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 12'h1;
            end
        end
        if (cs_n_s) begin
            nbits_d = 13'h0;
        end else if (cmd.rise) begin
            sh_d = {sh_q[6:0], cmd.sdi};
            if (nbits_q != 13'h1FFF) begin
                nbits_d = nbits_q + 13'h1;
            end
            if (nbits_q == 13'h7) begin
                op_d = {sh_q[6:0], cmd.sdi};
            end else if (nbits_q >= 13'h8 && nbits_q < 13'h20) begin
                addr_d = {addr_q[ADDR_W-2:0], cmd.sdi};
            end
            if (nbits_q[2:0] == 3'h7) begin
                data_d = {sh_q[6:0], cmd.sdi};
            end
        end
        if (cmd.fall && !cs_n_s && !deep_q) begin
            if (op_q == OP_RDSR && nbits_q >= 13'h8) begin
                out_d = (nbits_q[2:0] == 3'h0) ? status_word << 1
                                               : out_q << 1;
            end
        end
        if (cmd.fall && nbits_q == 13'h8) begin
            out_d = status_word;
        end
        // Frame end decodes at the chip select rise
        if (end_frame && !deep_q) begin
            if (mult8 && nbits_q == 13'h8) begin
                unique case (op_q)
                    OP_WRITE_UNLOCK_CMD: wel_d = 1'b1;
                    OP_WRITE_RELOCK_CMD: wel_d = 1'b0;
                    OP_SLEEP: deep_d = (cyc_q == SFP_CYC_NONE);
                    OP_BULK: begin
                        // Rejected attempts still drop the latch
                        if (wel_q && !blocked && cyc_q == SFP_CYC_NONE &&
                            bp_q == 2'h0) begin
                            cyc_d = SFP_CYC_ERASE;
                            cnt_d = 12'(BULK_CYCLES);
                            wipe_d = 1'b1;
                            wipe_all_d = 1'b1;
                        end
                        wel_d = 1'b0;
                    end
                    default: ;
                endcase
            end
            if (mult8 && nbits_q == 13'h10 && op_q == OP_STATUS_WRITE_CMD) begin
                if (wel_q && !blocked && !hw_lock &&
                    cyc_q == SFP_CYC_NONE) begin
                    bpn_d = data_q[BIT_BP_HI:BIT_BP_LO];
                    lockn_d = data_q[BIT_LOCK];
                    cyc_d = SFP_CYC_STAT;
                    cnt_d = 12'(STAT_WR_CYC);
                end
                wel_d = 1'b0;
            end
            if (mult8 && nbits_q == 13'h20 && op_q == OP_SECT) begin
                if (wel_q && !blocked && cyc_q == SFP_CYC_NONE &&
                    !sect_prot(bp_q, addr_q[SECT_LSB+:2])) begin
                    cyc_d = SFP_CYC_ERASE;
                    cnt_d = 12'(SECT_CYCLES);
                    wipe_d = 1'b1;
                    wsect_d = addr_q[SECT_LSB+:2];
                end
                wel_d = 1'b0;
            end
            if (mult8 && nbits_q > 13'h20 && op_q == OP_PP) begin
                if (wel_q && !blocked && cyc_q == SFP_CYC_NONE &&
                    !sect_prot(bp_q, addr_q[SECT_LSB+:2])) begin
                    cyc_d = SFP_CYC_PROG;
                    cnt_d = 12'(PROG_CYC);
                    prog_d = 1'b1;
                    paddr_d = addr_q;
                    // Cell clears only bits given as zero
                    pmask_d = ~data_q;
                end
                wel_d = 1'b0;
            end
        end
        if (end_frame && deep_q && op_q == OP_WAKE &&
            nbits_q >= 13'h8) begin
            deep_d = 1'b0;
        end
        oe_d = !cs_n_s && !cmd.paused && !deep_q && op_q == OP_RDSR &&
               nbits_q >= 13'h8;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_q <= 8'h00;
            op_q <= 8'h00;
            data_q <= 8'h00;
            out_q <= 8'h00;
            nbits_q <= 13'h0;
            addr_q <= '0;
            cs_q <= 1'b0;
            wel_q <= 1'b0;
            lock_q <= LOCK_RESET;
            bp_q <= BP_RESET;
            bpn_q <= BP_RESET;
            lockn_q <= LOCK_RESET;
            deep_q <= 1'b0;
            cyc_q <= SFP_CYC_NONE;
            cnt_q <= 12'h0;
            puw_q <= ($clog2(PUW_CYCLES+1))'(PUW_CYCLES);
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            wipe_strobe <= 1'b0;
            wipe_sector <= 2'h0;
            wipe_all <= 1'b0;
            prog_strobe <= 1'b0;
            prog_addr <= '0;
            prog_mask <= 8'h00;
            busy <= 1'b0;
            active <= 1'b0;
            deep_sleep <= 1'b0;
            status_word <= 8'h00;
        end else begin
            sh_q <= sh_d;
            op_q <= op_d;
            data_q <= data_d;
            out_q <= out_d;
            nbits_q <= nbits_d;
            addr_q <= addr_d;
            cs_q <= cs_d;
            wel_q <= wel_d;
            lock_q <= lock_d;
            bp_q <= bp_d;
            bpn_q <= bpn_d;
            lockn_q <= lockn_d;
            deep_q <= deep_d;
            cyc_q <= cyc_d;
            cnt_q <= cnt_d;
            puw_q <= puw_d;
            sdo <= out_d[7];
            sdo_oe <= oe_d;
            wipe_strobe <= wipe_d;
            wipe_sector <= wsect_d;
            wipe_all <= wipe_all_d;
            prog_strobe <= prog_d;
            prog_addr <= paddr_d;
            prog_mask <= pmask_d;
            busy <= (cyc_d != SFP_CYC_NONE);
            active <= !cs_n_s || (cyc_d != SFP_CYC_NONE);
            deep_sleep <= deep_d;
            status_word <= {lock_d, 3'h0, bp_d, wel_d,
                            (cyc_d != SFP_CYC_NONE)};
        end
    end
endmodule : sfp_core

// ==== test/sfp_core_checker.sv ====
`timescale 1ns/10ps
module sfp_core_checker
    import sfp_pkg::*;
#(
    parameter int PUW_CYCLES = 4,
    parameter int BULK_CYCLES = 8,
    parameter int SECT_CYCLES = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic hold_n,
    input wire logic sdo_oe,
    input wire logic busy,
    input wire logic active,
    input wire logic deep_sleep,
    input wire logic [7:0] status_word,
    input wire logic wipe_strobe,
    input wire logic [1:0] wipe_sector,
    input wire logic wipe_all,
    input wire logic prog_strobe
);
    logic [1:0] bp;
    assign bp = status_word[BIT_BP_HI:BIT_BP_LO];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // Margins cover the two-flop pin synchronisers
    sequence sel_held;
        !cs_n [*8];
    endsequence
    sequence idle_held;
        (cs_n && !busy) [*8];
    endsequence
    busy_flag_a: assert property (status_word[BIT_BUSY] == busy)
        else $error("busy bit differs from busy output");
    active_sel_a: assert property (sel_held |-> active)
        else $error("selected but not active");
    standby_a: assert property (idle_held |-> !active)
        else $error("idle and deselected but still active");
    busy_active_a: assert property (busy [*2] |-> active)
        else $error("cycle running while in standby");
    deep_quiet_a: assert property (deep_sleep |-> !wipe_strobe && !prog_strobe)
        else $error("array change during deep sleep");
    wipe_busy_a: assert property (wipe_strobe |-> ##[0:2] busy)
        else $error("erase launched without busy");
    bulk_bp_a: assert property (wipe_strobe && wipe_all |-> bp == 2'h0)
        else $error("bulk erase with protect bits set");
    sector_prot_a: assert property (wipe_strobe && !wipe_all |->
        bp == 2'h0 || (bp == 2'h1 && wipe_sector != 2'h3) ||
        (bp == 2'h2 && !wipe_sector[1]))
        else $error("protected sector erased");
    wel_clear_a: assert property ($fell(busy) |-> ##[0:2] !status_word[BIT_WEL])
        else $error("latch still set after cycle");
    pause_float_a: assert property ((!hold_n && !sck) [*4] |-> ##1 !sdo_oe)
        else $error("output driven during pause");
endmodule : sfp_core_checker

bind sfp_core sfp_core_checker #(.PUW_CYCLES(PUW_CYCLES),
    .BULK_CYCLES(BULK_CYCLES), .SECT_CYCLES(SECT_CYCLES)) chk_u (
    .clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
    .sdo_oe(sdo_oe), .busy(busy), .active(active), .deep_sleep(deep_sleep),
    .status_word(status_word), .wipe_strobe(wipe_strobe),
    .wipe_sector(wipe_sector), .wipe_all(wipe_all),
    .prog_strobe(prog_strobe));

// ==== test/sfp_spi_master.sv ====
`timescale 1ns/10ps
module sfp_spi_master (
    input wire logic clk,
    output logic sck,
    output logic sdi,
    output logic cs_n,
    output logic hold_n
);
    initial begin
        sck = 1'b0;
        sdi = 1'b1;
        cs_n = 1'b1;
        hold_n = 1'b1;
    end
    // Four system clocks, half of the 200 ns link period
    task automatic half();
        repeat (4) @(negedge clk);
    endtask : half
    task automatic tick();
        half();
        sck = 1'b1;
        half();
        sck = 1'b0;
    endtask : tick
    // Clock is low here, so the pause starts and ends at once
    task automatic pause_link();
        hold_n = 1'b0;
        repeat (3) begin
            sdi = ~sdi;
            tick();
        end
        half();
        hold_n = 1'b1;
        half();
    endtask : pause_link
    task automatic frame(input logic [39:0] bits, input int n, input int stop);
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = bits[39 - i];
            tick();
            if (i == stop)
                pause_link();
        end
        half();
        cs_n = 1'b1;
        // Released line must not keep the last bit
        sdi = ~sdi;
        repeat (8) half();
    endtask : frame
endmodule : sfp_spi_master

// ==== test/serial_flash_protect_power_hold_tb_top.sv ====
`timescale 1ns/10ps
module serial_flash_protect_power_hold_tb_top;
    import sfp_pkg::*;
    logic clk, arst_n, guard_n, sck, sdi, cs_n, hold_n, sdo, sdo_oe;
    logic busy, active, deep_sleep, wipe_strobe, wipe_all, prog_strobe;
    logic [7:0] status_word, prog_mask;
    logic [1:0] wipe_sector;
    logic [ADDR_W-1:0] prog_addr;
    int err_count = 0;
    int cmp_count = 0;
    int wipe_cnt = 0;
    int prog_cnt = 0;
    logic [1:0] wsec_seen = 2'h0;
    logic [7:0] rd_sh = 8'h00;
    int cyc = 0;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    sfp_core #(.PUW_CYCLES(4), .BULK_CYCLES(300), .SECT_CYCLES(256)) dut_u (
        .clk(clk), .arst_n(arst_n), .sck(sck), .sdi(sdi), .cs_n(cs_n),
        .hold_n(hold_n), .guard_n(guard_n), .sdo(sdo), .sdo_oe(sdo_oe),
        .busy(busy), .active(active), .deep_sleep(deep_sleep),
        .status_word(status_word), .wipe_strobe(wipe_strobe),
        .wipe_sector(wipe_sector), .wipe_all(wipe_all),
        .prog_strobe(prog_strobe), .prog_addr(prog_addr),
        .prog_mask(prog_mask));
    sfp_spi_master m_u (.clk(clk), .sck(sck), .sdi(sdi), .cs_n(cs_n),
        .hold_n(hold_n));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        // Strobe and sector stand one cycle only, so catch them here
        if (wipe_strobe === 1'b1) begin
            wipe_cnt <= wipe_cnt + 1;
            wsec_seen <= wipe_sector;
        end
        if (prog_strobe === 1'b1)
            prog_cnt <= prog_cnt + 1;
        // Whole run needs about 14000 cycles
        if (cyc == 40000) begin
            err_count++;
            complete_run();
        end
    end
    // Master view of the serial output, taken at each link clock rise
    always @(posedge sck) begin
        if (cs_n === 1'b0)
            rd_sh <= {rd_sh[6:0], sdo};
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic [7:0] code);
        m_u.frame({code, 32'h0}, 8, -1);
    endtask : op
    task automatic wait_idle();
        for (int k = 0; k < 4000 && busy !== 1'b0; k++)
            @(negedge clk);
    endtask : wait_idle
    task automatic wr_status(input logic [7:0] d, input logic [7:0] bz);
        op(OP_WRITE_UNLOCK_CMD);
        m_u.frame({OP_STATUS_WRITE_CMD, d, 24'h0}, 16, -1);
        chk(8'(busy), bz);
        wait_idle();
    endtask : wr_status
    initial begin
        int lim[4];
        int n;
        logic ok;
        lim = '{4, 3, 2, 0};
        arst_n = 1'b0;
        guard_n = 1'b1;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (20) @(negedge clk);
        chk(status_word, 8'h00);
        op(OP_WRITE_UNLOCK_CMD);
        chk(status_word, 8'h02);
        op(OP_WRITE_RELOCK_CMD);
        chk(status_word, 8'h00);
        m_u.frame({OP_WRITE_UNLOCK_CMD, 32'h0}, 9, -1);
        chk(status_word, 8'h00);
        m_u.frame({OP_WRITE_UNLOCK_CMD, 32'h0}, 8, 3);
        chk(status_word, 8'h02);
        op(OP_WRITE_RELOCK_CMD);
        op(OP_BULK);
        chk(8'(wipe_cnt), 8'h00);
        $display("test latch and pause done");
        for (int bp = 0; bp < 4; bp++) begin
            wr_status(8'(bp << 2), 8'h01);
            chk(status_word, 8'(bp << 2));
            for (int s = 0; s < 4; s++) begin
                n = wipe_cnt;
                ok = (s < lim[bp]);
                op(OP_WRITE_UNLOCK_CMD);
                m_u.frame({OP_SECT, 7'h0, 2'(s), 15'h0, 8'h0}, 32, -1);
                chk(8'(wipe_cnt - n), 8'(ok));
                if (ok)
                    chk(8'(wsec_seen), 8'(s));
                chk(8'(busy), 8'(ok));
                wait_idle();
                chk(status_word, 8'(bp << 2));
            end
            n = wipe_cnt;
            op(OP_WRITE_UNLOCK_CMD);
            op(OP_BULK);
            chk(8'(wipe_cnt - n), 8'(bp == 0));
            wait_idle();
        end
        wr_status(8'h00, 8'h01);
        n = prog_cnt;
        op(OP_WRITE_UNLOCK_CMD);
        m_u.frame({OP_PP, 7'h0, 17'h08010, 8'hA5}, 40, -1);
        chk(8'(prog_cnt - n), 8'h01);
        chk(8'(prog_addr >> 9), 8'h40);
        chk(prog_addr[7:0], 8'h10);
        chk(prog_mask, 8'h5A);
        chk(8'(busy), 8'h01);
        wait_idle();
        chk(status_word, 8'h00);
        op(OP_WRITE_UNLOCK_CMD);
        m_u.frame({OP_RDSR, 32'h0}, 16, -1);
        chk(rd_sh, 8'h02);
        op(OP_WRITE_RELOCK_CMD);
        $display("test protect levels done");
        op(OP_SLEEP);
        chk(8'(deep_sleep), 8'h01);
        op(OP_WRITE_UNLOCK_CMD);
        chk(status_word, 8'h00);
        op(OP_WAKE);
        chk(8'(deep_sleep), 8'h00);
        $display("test deep sleep done");
        wr_status(8'h80, 8'h01);
        chk(status_word, 8'h80);
        @(negedge clk) guard_n = 1'b0;
        wr_status(8'h00, 8'h00);
        chk(status_word & 8'hFC, 8'h80);
        @(negedge clk) guard_n = 1'b1;
        wr_status(8'h00, 8'h01);
        chk(status_word, 8'h00);
        chk(8'(active), 8'h00);
        $display("test hardware lock done");
        complete_run();
    end
endmodule : serial_flash_protect_power_hold_tb_top
